// file: hdl/malbo_alu.sv
// What this block does
// RULE1: register add with carry sums working register, file register and carry; all flags
// RULE2: destination select zero writes working register, one writes back to file register
// RULE3: register add sums working register and file register, no carry in; all flags
// RULE4: immediate add with carry sums working register, immediate, carry; all flags
// RULE5: immediate add sums working register and immediate without carry; all flags
// RULE6: register AND of working and file register, steered by destination, only Z
// RULE7: immediate AND of working register and immediate into working register
// RULE8: bit clear zeroes one file register bit, others and flags untouched
// RULE9: bit set forces chosen bit 0..7 to one, others and flags untouched
// RULE10: carry is one on carry out of bit 7, zero otherwise
// RULE11: zero flag marks a zero result; half carry is carry out of bit 3
`timescale 1ns/100ps
`include "malbo_defines.svh"

module malbo_alu (
  // clock, reset, enable
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // request from the decoder, file read data included
  input  wire logic                   req_valid,
  input  wire malbo_pkg::malbo_req_s  req,
  // architectural state
  output logic [`MALBO_DATA_W-1:0]    working_register_r,
  output malbo_pkg::malbo_flags_s     flags_r,
  // file register write-back
  output malbo_pkg::malbo_fwr_s       fwr_r,
  // one-cycle completion strobe
  output logic                        done_r
);

  function automatic logic [4:0] nib_add(input logic [3:0] a,
                                         input logic [3:0] b,
                                         input logic       ci);
    nib_add = {1'b0, a} + {1'b0, b} + {4'h0, ci};
  endfunction

  function automatic logic is_op(input malbo_pkg::malbo_op_e o,
                                 input malbo_pkg::malbo_op_e want);
    is_op = (o == want);
  endfunction

  logic [`MALBO_DATA_W-1:0] working_register_nxt;
  malbo_pkg::malbo_flags_s  flags_nxt;
  malbo_pkg::malbo_fwr_s    fwr_nxt;
  logic                     done_nxt;

  // operation class decode
  wire logic op_adcr = is_op(req.op, malbo_pkg::add_reg_with_carry_op);
  wire logic op_addr = is_op(req.op, malbo_pkg::add_reg_op);
  wire logic op_adci = is_op(req.op, malbo_pkg::add_imm_with_carry_op);
  wire logic op_addi = is_op(req.op, malbo_pkg::add_imm_op);
  wire logic op_andr = is_op(req.op, malbo_pkg::and_reg_op);
  wire logic op_andi = is_op(req.op, malbo_pkg::and_imm_op);
  wire logic op_bclr = is_op(req.op, malbo_pkg::bit_clear_op);
  wire logic op_bset = is_op(req.op, malbo_pkg::bit_set_op);

  wire logic is_add  = op_adcr | op_addr | op_adci | op_addi;
  wire logic is_and  = op_andr | op_andi;
  wire logic is_bit  = op_bclr | op_bset;
  wire logic is_imm  = op_adci | op_addi | op_andi;
  wire logic reg_arith = op_adcr | op_addr | op_andr;
  wire logic go      = req_valid & ce;

  // carry in only for the with-carry forms
  wire logic carry_in = (op_adcr | op_adci) & flags_r.c;               // [RULE1] [RULE4]

  wire logic [`MALBO_DATA_W-1:0] opb = is_imm ? req.imm : req.file_data;

  // adder split at the nibble so the half carry falls out directly
  wire logic [4:0] lo_sum = nib_add(working_register_r[3:0], opb[3:0], carry_in);
  wire logic [4:0] hi_sum = nib_add(working_register_r[7:4], opb[7:4], lo_sum[4]);
  wire logic [`MALBO_DATA_W-1:0] add_res = {hi_sum[3:0], lo_sum[3:0]}; // [RULE3] [RULE5]
  wire logic add_hc  = lo_sum[4];                                      // [RULE11]
  wire logic add_c   = hi_sum[4];                                      // [RULE10]

  wire logic [`MALBO_DATA_W-1:0] and_res = working_register_r & opb;   // [RULE6] [RULE7]

  wire logic [`MALBO_DATA_W-1:0] bit_mask = 8'h01 << req.bitsel;
  wire logic [`MALBO_DATA_W-1:0] bit_res  = op_bset ? (req.file_data | bit_mask)  // [RULE9]
                                                    : (req.file_data & ~bit_mask); // [RULE8]

  wire logic [`MALBO_DATA_W-1:0] result = is_add ? add_res :
                                          is_and ? and_res : bit_res;
  wire logic res_zero = (result == 8'h00);                             // [RULE11]

  // destination steering
  wire logic to_file = (reg_arith & req.dest) | is_bit;                // [RULE2]
  wire logic to_wreg = (reg_arith & ~req.dest) | is_imm;               // [RULE2]

  always_comb begin
    working_register_nxt = working_register_r;
    flags_nxt            = flags_r;
    fwr_nxt              = '{en: 1'b0, addr: req.addr, data: result};
    done_nxt             = 1'b0;
    if (req_valid) begin
      done_nxt   = is_add | is_and | is_bit;
      fwr_nxt.en = to_file;
      if (to_wreg) begin
        working_register_nxt = result;
      end
      if (is_add) begin
        flags_nxt = '{z: res_zero, half_carry_flag: add_hc, c: add_c}; // [RULE10]
      end else if (is_and) begin
        flags_nxt.z = res_zero;                                        // [RULE6]
      end
    end
  end

  // enable low holds every flop, reset included
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (rst) begin
        working_register_r <= `MALBO_WREG_RST;
        flags_r            <= '{default: `MALBO_FLAG_RST};
        fwr_r              <= '0;
        done_r             <= 1'b0;
      end else begin
        working_register_r <= working_register_nxt;
        flags_r            <= flags_nxt;
        fwr_r              <= fwr_nxt;
        done_r             <= done_nxt;
      end
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  adc_reg_sum_a: assert property (go && op_adcr |=> // [RULE1]
      ($past(req.dest) ? fwr_r.data : working_register_r) ==
      8'($past(working_register_r) + $past(req.file_data) + {7'h00, $past(flags_r.c)}))
    else $error("register add with carry gives a wrong sum");

  dest_steer_a: assert property (go && reg_arith |=> // [RULE2]
      fwr_r.en == $past(req.dest) &&
      ($past(req.dest) ? fwr_r.data == $past(result) &&
                         working_register_r == $past(working_register_r)
                       : working_register_r == $past(result)))
    else $error("destination select steers the result wrongly");

  add_reg_sum_a: assert property (go && op_addr |=> // [RULE3]
      ($past(req.dest) ? fwr_r.data : working_register_r) ==
      8'($past(working_register_r) + $past(req.file_data)))
    else $error("register add gives a wrong sum");

  adc_imm_sum_a: assert property (go && op_adci |=> !fwr_r.en && // [RULE4]
      working_register_r ==
      8'($past(working_register_r) + $past(req.imm) + {7'h00, $past(flags_r.c)}))
    else $error("immediate add with carry gives a wrong sum");

  add_imm_sum_a: assert property (go && op_addi |=> !fwr_r.en && // [RULE5]
      working_register_r == 8'($past(working_register_r) + $past(req.imm)))
    else $error("immediate add gives a wrong sum");

  and_reg_flags_a: assert property (go && op_andr |=> // [RULE6]
      flags_r.c == $past(flags_r.c) &&
      flags_r.half_carry_flag == $past(flags_r.half_carry_flag) &&
      flags_r.z == (($past(working_register_r) & $past(req.file_data)) == 8'h00))
    else $error("register AND disturbs carry or misreports zero");

  and_reg_res_a: assert property (go && op_andr |=> // [RULE6]
      ($past(req.dest) ? fwr_r.data : working_register_r) ==
      ($past(working_register_r) & $past(req.file_data)))
    else $error("register AND gives a wrong result");

  and_imm_res_a: assert property (go && op_andi |=> // [RULE7]
      working_register_r == ($past(working_register_r) & $past(req.imm)) && !fwr_r.en)
    else $error("immediate AND gives a wrong result");

  and_imm_zero_a: assert property (go && op_andi |=> // [RULE7]
      flags_r.c == $past(flags_r.c) &&
      flags_r.half_carry_flag == $past(flags_r.half_carry_flag) &&
      flags_r.z == (($past(working_register_r) & $past(req.imm)) == 8'h00))
    else $error("immediate AND disturbs carry or misreports zero");

  bit_clear_a: assert property (go && op_bclr |=> fwr_r.en && // [RULE8]
      !fwr_r.data[$past(req.bitsel)] && flags_r == $past(flags_r) &&
      (fwr_r.data | (8'h01 << $past(req.bitsel))) ==
      ($past(req.file_data) | (8'h01 << $past(req.bitsel))))
    else $error("bit clear alters the wrong bits or the flags");

  bit_wreg_hold_a: assert property (go && is_bit |=> // [RULE8]
      working_register_r == $past(working_register_r) && fwr_r.addr == $past(req.addr))
    else $error("bit operation touched the working register or the wrong address");

  file_addr_a: assert property (go && to_file |=> fwr_r.en && // [RULE2]
      fwr_r.addr == $past(req.addr))
    else $error("write-back goes to the wrong file register");

  bit_set_a: assert property (go && op_bset |=> fwr_r.en && // [RULE9]
      fwr_r.data == ($past(req.file_data) | (8'h01 << $past(req.bitsel))) &&
      flags_r == $past(flags_r) && working_register_r == $past(working_register_r))
    else $error("bit set alters the wrong bits or the flags");

  carry_out_a: assert property (go && is_add |=> // [RULE10]
      flags_r.c == (({1'b0, $past(working_register_r)} + {1'b0, $past(opb)} +
                     {8'h00, $past(carry_in)}) > 9'h0ff))
    else $error("carry flag does not follow carry out of bit 7");

  half_zero_a: assert property (go && is_add |=> // [RULE11]
      flags_r.half_carry_flag ==
        (({1'b0, $past(working_register_r[3:0])} + {1'b0, $past(opb[3:0])} +
          {4'h0, $past(carry_in)}) > 5'h0f) &&
      flags_r.z == (8'($past(working_register_r) + $past(opb) +
                       {7'h00, $past(carry_in)}) == 8'h00))
    else $error("half carry or zero flag wrong after add");

  freeze_a: assert property (!ce |=> $stable(working_register_r) && $stable(flags_r) &&
                             $stable(fwr_r) && $stable(done_r))
    else $error("state moved while clock enable was low");

  done_pulse_a: assert property (go |=> done_r == $past(is_add | is_and | is_bit)) // [RULE1]
    else $error("completion strobe does not follow an accepted instruction");

  idle_quiet_a: assert property (ce && !req_valid |=> !done_r && !fwr_r.en && // [RULE2]
      $stable(working_register_r) && $stable(flags_r))
    else $error("state moved without a request");

  cov_adc_carry_c: cover property (go && op_adcr && flags_r.c ##1 flags_r.c);
  cov_and_zero_c:  cover property (go && op_andr && req.dest ##1 flags_r.z && fwr_r.en);
  cov_bit_seq_c:   cover property (go && op_bset ##1 go && op_bclr);
  cov_half_c:      cover property (go && op_addi ##1 flags_r.half_carry_flag && !flags_r.c);
  cov_freeze_c:    cover property (done_r && !ce ##1 done_r);

endmodule // malbo_alu

// file: hdl/malbo_defines.svh
`ifndef MALBO_DEFINES_SVH
`define MALBO_DEFINES_SVH

// widths
`define MALBO_DATA_W      8
`define MALBO_FILE_AW     6
`define MALBO_BIT_W       3
// highest file register address
`define MALBO_FILE_MAX    6'h3f
// reset values
`define MALBO_WREG_RST    8'h00
`define MALBO_FLAG_RST    1'b0
// flag positions inside the flag word {z, half carry, c}
`define MALBO_FLAG_C_POS  0
`define MALBO_FLAG_HC_POS 1
`define MALBO_FLAG_Z_POS  2
// cycles from request to result
`define MALBO_OP_CYCLES   1

`endif

// file: hdl/malbo_pkg.sv
`include "malbo_defines.svh"

package malbo_pkg;

  typedef enum logic [3:0] {
    nop_op,
    add_reg_with_carry_op,
    add_reg_op,
    add_imm_with_carry_op,
    add_imm_op,
    and_reg_op,
    and_imm_op,
    bit_clear_op,
    bit_set_op
  } malbo_op_e;

  typedef logic [`MALBO_DATA_W-1:0]  malbo_data_t;
  typedef logic [`MALBO_FILE_AW-1:0] malbo_addr_t;
  typedef logic [`MALBO_BIT_W-1:0]   malbo_bit_t;

  typedef struct packed {
    malbo_op_e   op;
    malbo_addr_t addr;
    logic        dest;
    malbo_bit_t  bitsel;
    malbo_data_t imm;
    malbo_data_t file_data;
  } malbo_req_s;

  typedef struct packed {
    logic z;
    logic half_carry_flag;
    logic c;
  } malbo_flags_s;

  typedef struct packed {
    logic        en;
    malbo_addr_t addr;
    malbo_data_t data;
  } malbo_fwr_s;

endpackage

// file: bench/malbo_fmem.sv
`timescale 1ns/100ps

module malbo_fmem (
  // clock
  input  wire logic                   mclk,
  // write-back from the block, read port for the request
  input  wire malbo_pkg::malbo_fwr_s  fwr,
  input  wire malbo_pkg::malbo_addr_t rd_addr,
  output malbo_pkg::malbo_data_t      rd_data
);
  malbo_pkg::malbo_data_t mem [64];

  // a write still in flight is forwarded to a read of the same place
  assign rd_data = (fwr.en && fwr.addr == rd_addr) ? fwr.data : mem[rd_addr];

  initial for (int k = 0; k < 64; k++) mem[k] = 8'(k * 59 + 17);

  always @(posedge mclk) if (fwr.en) mem[fwr.addr] <= fwr.data;
endmodule // malbo_fmem

// file: bench/mcu_add_logic_bit_ops_bench.sv
`timescale 1ns/100ps

module mcu_add_logic_bit_ops_bench;
  logic                    mclk = 1'b0;
  logic                    rst = 1'b1;
  logic                    ce = 1'b1;
  logic                    req_valid = 1'b0;
  logic                    done_r;
  logic                    ce_q;
  malbo_pkg::malbo_req_s   rq = '0;
  malbo_pkg::malbo_req_s   req;
  malbo_pkg::malbo_data_t  fdata;
  malbo_pkg::malbo_data_t  working_register_r;
  malbo_pkg::malbo_flags_s flags_r;
  malbo_pkg::malbo_fwr_s   fwr_r;
  // bench copy of the architectural state
  logic [7:0]              w = 8'h00;
  logic [2:0]              f = 3'h0;
  logic [7:0]              m [64];
  logic [25:0]             notes [$];
  logic [25:0]             note;
  logic [25:0]             got_w;
  logic [25:0]             got_f;
  logic [25:0]             got_b;
  logic [31:0]             rnd = 32'h42a3;
  int                      failures = 0;
  int                      checks = 0;
  int                      cyc = 0;

  assign req = {rq.op, rq.addr, rq.dest, rq.bitsel, rq.imm, fdata};
  assign got_w = 26'(working_register_r);
  assign got_f = 26'(flags_r);
  assign got_b = 26'({fwr_r.en, fwr_r.en ? {fwr_r.addr, fwr_r.data} : 14'h0});

  malbo_alu DUT (.mclk(mclk), .rst(rst), .ce(ce), .req_valid(req_valid), .req(req),
    .working_register_r(working_register_r), .flags_r(flags_r), .fwr_r(fwr_r),
    .done_r(done_r));
  malbo_fmem fmem (.mclk(mclk), .fwr(fwr_r), .rd_addr(rq.addr), .rd_data(fdata));

  initial forever #2.5 mclk = ~mclk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  task results;
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task check(input string what, input logic [25:0] exp, input logic [25:0] seen);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one random instruction, with its expected outcome queued
  task step;
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] x;
    logic [7:0] r;
    logic       cin;
    logic       fw;
    rnd = lfsr(rnd);
    ce = rnd[20] | rnd[21];
    req_valid = rnd[22] | rnd[23];
    rq = {rnd[3:0], rnd[9:4], rnd[10], rnd[13:11], rnd[31:24], 8'h00};
    if (!(ce && req_valid && rq.op inside {[malbo_pkg::add_reg_with_carry_op :
        malbo_pkg::bit_set_op]})) return;
    x = rq.op inside {malbo_pkg::add_imm_with_carry_op, malbo_pkg::add_imm_op,
        malbo_pkg::and_imm_op} ? rq.imm : m[rq.addr];
    cin = f[0] & (rq.op inside {malbo_pkg::add_reg_with_carry_op,
        malbo_pkg::add_imm_with_carry_op});
    s = w + x + cin;
    h = w[3:0] + x[3:0] + cin;
    fw = rq.op inside {malbo_pkg::bit_clear_op, malbo_pkg::bit_set_op} || (rq.dest &&
        rq.op inside {malbo_pkg::add_reg_with_carry_op, malbo_pkg::add_reg_op,
        malbo_pkg::and_reg_op});
    case (rq.op)
      malbo_pkg::bit_clear_op: r = x & ~(8'h01 << rq.bitsel);
      malbo_pkg::bit_set_op: r = x | (8'h01 << rq.bitsel);
      malbo_pkg::and_reg_op, malbo_pkg::and_imm_op: begin
        r = w & x;
        f[2] = r == 8'h00;
      end
      default: begin
        r = s[7:0];
        f = {r == 8'h00, h[4], s[8]};
      end
    endcase
    if (fw) m[rq.addr] = r;
    else w = r;
    notes.push_back({w, f, fw, fw ? {rq.addr, r} : 14'h0});
  endtask

  always @(posedge mclk) ce_q <= ce;

  always @(negedge mclk) begin
    if (ce_q && done_r === 1'b1) begin
      if (notes.size() == 0) begin
        check("spurious done", 26'h0, 26'h1);
      end else begin
        note = notes.pop_front();
        check("wreg", 26'(note[25:18]), got_w);
        check("flags", 26'(note[17:15]), got_f);
        check("write-back", 26'(note[14:0]), got_b);
      end
    end else if (ce_q && {done_r, fwr_r.en} !== 2'b00) begin
      check("idle strobes", 26'h0, 26'h1);
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      failures++;
      results();
    end
  end

  initial begin
    for (int k = 0; k < 64; k++) m[k] = 8'(k * 59 + 17);
    repeat (5) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    repeat (3000) @(negedge mclk) step();
    @(negedge mclk) begin
      {rst, ce, req_valid} = 3'b110;
      w = 8'h00;
      f = 3'h0;
    end
    @(negedge mclk) begin
      check("reset", 26'h0, {working_register_r, flags_r, fwr_r.en, done_r, 13'h0});
      rst = 1'b0;
    end
    repeat (1000) @(negedge mclk) step();
    @(negedge mclk) {ce, req_valid} = 2'b10;
    repeat (3) @(negedge mclk);
    check("pending", 26'h0, 26'(notes.size()));
    results();
  end
endmodule // mcu_add_logic_bit_ops_bench
